// file: hdl/dieg_sync_gate.v
// one port of pin synchronisers with input gating and edge detection
// assumes pins are asynchronous to clk_i; enables come from clk_i logic
module dieg_sync_gate #(
    parameter WIDTH = 8
) (
    // clock and control
    input wire clk_i,
    input wire reset_i,
    input wire ce_i,
    // pins and gates
    input wire [WIDTH-1:0] pin_i,
    input wire [WIDTH-1:0] en_i,
    // gated view
    output wire [WIDTH-1:0] level_o,
    output wire [WIDTH-1:0] rise_o,
    output wire [WIDTH-1:0] fall_o
);

reg [WIDTH-1:0] meta_r;
reg [WIDTH-1:0] sync_r;
reg [WIDTH-1:0] gated_r;
reg [WIDTH-1:0] en_d_r;

always @(posedge clk_i) begin
    if (reset_i) begin
        meta_r <= {WIDTH{1'b0}};
        sync_r <= {WIDTH{1'b0}};
        gated_r <= {WIDTH{1'b0}};
        en_d_r <= {WIDTH{1'b0}};
    end else if (ce_i) begin
        meta_r <= pin_i;
        sync_r <= meta_r;
        gated_r <= sync_r & en_i;
        en_d_r <= en_i;
    end
end

// disabled lines sit at 0; edges only while enabled in both cycles
assign level_o = sync_r & en_i;
assign rise_o = level_o & ~gated_r & en_d_r & en_i;
assign fall_o = ~level_o & gated_r & en_d_r & en_i;

endmodule // dieg_sync_gate

// file: hdl/dieg_top.v
// digital input enable gating for two 8-bit pin ports
// assumes a core register port on clk_i and asynchronous pin levels
//
// Overview of operation
// R1: first port bit 7 gates line 7, wake
// R2: first port bit 6 gates line 6, wake
// R3: software clears bits 7,6 with crystal running
// R4: first port bit 5 gates line 5, wake
// R5: first port bit 4 gates input, wake, request
// R6: first port bit 3 gates line 3, wake
// R7: software writes zeros to reserved bits 2,1
// R8: first port bit 0 gates input, wake, request
// R9: software clears enable for analog input pins
// R10: second port bits 7,6 gate input, wake
// R11: second port bit 5 gates input, wake, request
// R12: second port bits 4..1 gate input, wake
// R13: second port bit 0 gates input, wake, request
// R14: request flags set on edge, software clears
// R15: disabled inputs held constant, no false edges
`include "dieg_consts.vh"

module dieg_top (
    // clock, reset, enable
    input wire clk_i,
    input wire reset_i,
    input wire ce_i,
    // register port
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output wire [7:0] rdata_o,
    // pins
    input wire [7:0] first_port_pin_i,
    input wire [7:0] second_port_pin_i,
    // pad input buffer enables
    output wire [7:0] first_port_ie_o,
    output wire [7:0] second_port_ie_o,
    // gated inputs to the core
    output wire [7:0] first_port_in_o,
    output wire [7:0] second_port_in_o,
    // events
    output wire wake_o,
    output wire [1:0] pin_req_o,
    output wire irq_o
);

// registers
reg [7:0] first_gate_r;
reg [7:0] second_gate_r;
reg [7:0] edge_sel_r;
reg [1:0] pin_req_r;
reg [`DIEG_ST_WIDTH-1:0] status_r;
reg [`DIEG_ST_WIDTH-1:0] mask_r;
reg [7:0] rdata_r;

// output flops
reg [7:0] first_ie_r;
reg [7:0] second_ie_r;
reg [7:0] first_in_r;
reg [7:0] second_in_r;
reg wake_r;
reg irq_r;

// next values
reg [7:0] first_gate_nxt;
reg [7:0] second_gate_nxt;
reg [7:0] edge_sel_nxt;
reg [1:0] pin_req_nxt;
reg [`DIEG_ST_WIDTH-1:0] status_nxt;
reg [`DIEG_ST_WIDTH-1:0] mask_nxt;
reg [7:0] rdata_nxt;

// gated pin view
wire [7:0] first_en;
wire [7:0] second_en;
wire [7:0] first_level;
wire [7:0] second_level;
wire [7:0] first_rise;
wire [7:0] first_fall;
wire [7:0] second_rise;
wire [7:0] second_fall;

// event terms
wire wake_evt;
wire src0_rise;
wire src0_fall;
wire src1_rise;
wire src1_fall;
wire [1:0] src0_mode;
wire [1:0] src1_mode;
wire req0_evt;
wire req1_evt;
wire [`DIEG_ST_WIDTH-1:0] status_set;

// first port: bits 7..3 and 0 gate their lines, 2..1 have no gate
assign first_en[7] = first_gate_r[7]; // [R1]
assign first_en[6] = first_gate_r[6]; // [R2]
assign first_en[5] = first_gate_r[5]; // [R4]
assign first_en[4] = first_gate_r[4]; // [R5]
assign first_en[3] = first_gate_r[3]; // [R6]
assign first_en[2:1] = 2'h3;
assign first_en[0] = first_gate_r[0]; // [R8]

// second port: every bit gates its own line
assign second_en[7:6] = second_gate_r[7:6]; // [R10]
assign second_en[5] = second_gate_r[5]; // [R11]
assign second_en[4:1] = second_gate_r[4:1]; // [R12]
assign second_en[0] = second_gate_r[0]; // [R13]

dieg_sync_gate #(
    .WIDTH(8)
) u_first_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .pin_i(first_port_pin_i),
    .en_i(first_en),
    .level_o(first_level),
    .rise_o(first_rise),
    .fall_o(first_fall)
); // [R15]

dieg_sync_gate #(
    .WIDTH(8)
) u_second_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .pin_i(second_port_pin_i),
    .en_i(second_en),
    .level_o(second_level),
    .rise_o(second_rise),
    .fall_o(second_fall)
); // [R15]

// any toggle on an enabled line wakes the system
assign wake_evt = (|(first_rise | first_fall))
    | (|(second_rise | second_fall)); // [R1] [R2] [R4] [R6] [R10] [R12]

// shared request sources, each already gated by its own enable
assign src0_rise = edge_sel_r[`DIEG_ES_SRC0_PIN]
    ? second_rise[`DIEG_SRC0_SECOND_LINE]
    : first_rise[`DIEG_SRC0_FIRST_LINE]; // [R8] [R11]
assign src0_fall = edge_sel_r[`DIEG_ES_SRC0_PIN]
    ? second_fall[`DIEG_SRC0_SECOND_LINE]
    : first_fall[`DIEG_SRC0_FIRST_LINE]; // [R8] [R11]
assign src1_rise = edge_sel_r[`DIEG_ES_SRC1_PIN]
    ? first_rise[`DIEG_SRC1_FIRST_LINE]
    : second_rise[`DIEG_SRC1_SECOND_LINE]; // [R5] [R13]
assign src1_fall = edge_sel_r[`DIEG_ES_SRC1_PIN]
    ? first_fall[`DIEG_SRC1_FIRST_LINE]
    : second_fall[`DIEG_SRC1_SECOND_LINE]; // [R5] [R13]

assign src0_mode = edge_sel_r[`DIEG_ES_SRC0_LSB+1:`DIEG_ES_SRC0_LSB];
assign src1_mode = edge_sel_r[`DIEG_ES_SRC1_LSB+1:`DIEG_ES_SRC1_LSB];

// reserved edge code triggers nothing
assign req0_evt =
    ((src0_mode == `DIEG_EDGE_BOTH) & (src0_rise | src0_fall))
    | ((src0_mode == `DIEG_EDGE_RISE) & src0_rise)
    | ((src0_mode == `DIEG_EDGE_FALL) & src0_fall); // [R14]
assign req1_evt =
    ((src1_mode == `DIEG_EDGE_BOTH) & (src1_rise | src1_fall))
    | ((src1_mode == `DIEG_EDGE_RISE) & src1_rise)
    | ((src1_mode == `DIEG_EDGE_FALL) & src1_fall); // [R14]

assign status_set = {req1_evt, req0_evt, wake_evt};

// register writes, request flags and sticky status
always @* begin
    first_gate_nxt = first_gate_r;
    second_gate_nxt = second_gate_r;
    edge_sel_nxt = edge_sel_r;
    pin_req_nxt = pin_req_r;
    status_nxt = status_r;
    mask_nxt = mask_r;
    if (wr_i) begin
        if (addr_i == `DIEG_FIRST_GATE_ADDR) begin
            // reserved bits are not stored
            first_gate_nxt = wdata_i & `DIEG_FIRST_GATE_MASK;
        end else if (addr_i == `DIEG_SECOND_GATE_ADDR) begin
            second_gate_nxt = wdata_i;
        end else if (addr_i == `DIEG_EDGE_SEL_ADDR) begin
            edge_sel_nxt = wdata_i;
        end else if (addr_i == `DIEG_PIN_REQ_ADDR) begin
            pin_req_nxt = wdata_i[1:0]; // [R14]
        end else if (addr_i == `DIEG_EVT_MASK_ADDR) begin
            mask_nxt = wdata_i[`DIEG_ST_WIDTH-1:0];
        end
    end
    if (rd_i && (addr_i == `DIEG_EVT_STATUS_ADDR)) begin
        status_nxt = {`DIEG_ST_WIDTH{1'b0}};
    end
    // hardware set wins over software clear
    pin_req_nxt = pin_req_nxt | {req1_evt, req0_evt}; // [R14]
    status_nxt = status_nxt | status_set;
end

// read data, valid only in the cycle after the strobe
always @* begin
    rdata_nxt = 8'h00;
    if (rd_i) begin
        if (addr_i == `DIEG_EDGE_SEL_ADDR) begin
            rdata_nxt = edge_sel_r;
        end else if (addr_i == `DIEG_PIN_REQ_ADDR) begin
            rdata_nxt = {6'h00, pin_req_r};
        end else if (addr_i == `DIEG_EVT_STATUS_ADDR) begin
            rdata_nxt = {5'h00, status_r};
        end else if (addr_i == `DIEG_EVT_MASK_ADDR) begin
            rdata_nxt = {5'h00, mask_r};
        end else if (addr_i == `DIEG_FIRST_LEVEL_ADDR) begin
            rdata_nxt = first_level;
        end else if (addr_i == `DIEG_SECOND_LEVEL_ADDR) begin
            rdata_nxt = second_level;
        end else begin
            // gate registers are write-only; unmapped reads give zero
            rdata_nxt = 8'h00;
        end
    end
end

always @(posedge clk_i) begin
    if (reset_i) begin
        first_gate_r <= `DIEG_FIRST_GATE_RST; // [R1] [R2] [R4] [R5]
        second_gate_r <= `DIEG_SECOND_GATE_RST; // [R10] [R11] [R12]
        edge_sel_r <= `DIEG_EDGE_SEL_RST;
        pin_req_r <= 2'h0;
        status_r <= {`DIEG_ST_WIDTH{1'b0}};
        mask_r <= `DIEG_MASK_RST;
        rdata_r <= 8'h00;
    end else if (ce_i) begin
        first_gate_r <= first_gate_nxt; // [R3] [R6] [R7] [R8] [R9]
        second_gate_r <= second_gate_nxt; // [R13]
        edge_sel_r <= edge_sel_nxt;
        pin_req_r <= pin_req_nxt;
        status_r <= status_nxt;
        mask_r <= mask_nxt;
        rdata_r <= rdata_nxt;
    end
end

// registered outputs
always @(posedge clk_i) begin
    if (reset_i) begin
        first_ie_r <= `DIEG_FIRST_GATE_RST | `DIEG_FIRST_UNGATED;
        second_ie_r <= `DIEG_SECOND_GATE_RST;
        first_in_r <= 8'h00;
        second_in_r <= 8'h00;
        wake_r <= 1'b0;
        irq_r <= 1'b0;
    end else if (ce_i) begin
        first_ie_r <= first_en;
        second_ie_r <= second_en;
        first_in_r <= first_level; // [R15]
        second_in_r <= second_level; // [R15]
        wake_r <= wake_evt;
        irq_r <= |(status_nxt & mask_nxt);
    end
end

assign rdata_o = rdata_r;
assign first_port_ie_o = first_ie_r;
assign second_port_ie_o = second_ie_r;
assign first_port_in_o = first_in_r;
assign second_port_in_o = second_in_r;
assign wake_o = wake_r;
assign pin_req_o = pin_req_r;
assign irq_o = irq_r;

endmodule // dieg_top

// file: shared/dieg_consts.vh
// offsets, field positions and reset values of the input gating block
// assumes an 8-bit register port with 8-bit addresses
`ifndef DIEG_CONSTS_VH
`define DIEG_CONSTS_VH

// register offsets
`define DIEG_FIRST_GATE_ADDR 8'h0D
`define DIEG_SECOND_GATE_ADDR 8'h0E
`define DIEG_EDGE_SEL_ADDR 8'h30
`define DIEG_PIN_REQ_ADDR 8'h31
`define DIEG_EVT_STATUS_ADDR 8'h32
`define DIEG_EVT_MASK_ADDR 8'h33
`define DIEG_FIRST_LEVEL_ADDR 8'h34
`define DIEG_SECOND_LEVEL_ADDR 8'h35

// reset values
`define DIEG_FIRST_GATE_RST 8'hF9
`define DIEG_SECOND_GATE_RST 8'hFF
`define DIEG_EDGE_SEL_RST 8'h00
`define DIEG_MASK_RST 3'h0

// first port gate bits that really exist (2 and 1 reserved)
`define DIEG_FIRST_GATE_MASK 8'hF9
// reserved lines have no gate and stay enabled
`define DIEG_FIRST_UNGATED 8'h06

// edge select fields
`define DIEG_ES_SRC0_LSB 0
`define DIEG_ES_SRC1_LSB 2
`define DIEG_ES_SRC0_PIN 4
`define DIEG_ES_SRC1_PIN 5
`define DIEG_EDGE_BOTH 2'h0
`define DIEG_EDGE_RISE 2'h1
`define DIEG_EDGE_FALL 2'h2

// shared request source lines
`define DIEG_SRC0_FIRST_LINE 0
`define DIEG_SRC0_SECOND_LINE 5
`define DIEG_SRC1_SECOND_LINE 0
`define DIEG_SRC1_FIRST_LINE 4

// event status fields
`define DIEG_ST_WAKE 0
`define DIEG_ST_REQ0 1
`define DIEG_ST_REQ1 2
`define DIEG_ST_WIDTH 3

`endif

// file: verification/dieg_checker.sv
// port assertions for the input gating block
// assumes ce_i is high whenever reset_i is applied
`include "dieg_consts.vh"
module dieg_checker (
    input wire clk_i,
    input wire reset_i,
    input wire ce_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire [7:0] first_port_ie_o,
    input wire [7:0] second_port_ie_o,
    input wire [7:0] first_port_in_o,
    input wire [7:0] second_port_in_o,
    input wire wake_o,
    input wire [1:0] pin_req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    property p_rst;
        disable iff (1'b0) reset_i && ce_i |=> first_port_ie_o == 8'hFF
            && second_port_ie_o == 8'hFF && !wake_o && pin_req_o == 2'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_wr_a;
        ce_i && wr_i && addr_i == `DIEG_FIRST_GATE_ADDR ##1 ce_i && !wr_i
            |=> first_port_ie_o == ($past(wdata_i, 2) | `DIEG_FIRST_UNGATED);
    endproperty
    a_wr_a: assert property (p_wr_a) else $error("first ie");
    property p_wr_b;
        ce_i && wr_i && addr_i == `DIEG_SECOND_GATE_ADDR ##1 ce_i && !wr_i
            |=> second_port_ie_o == $past(wdata_i, 2);
    endproperty
    a_wr_b: assert property (p_wr_b) else $error("second ie");
    property p_gate_a;
        (first_port_in_o & ~first_port_ie_o & ~$past(first_port_ie_o)) == 0;
    endproperty
    a_gate_a: assert property (p_gate_a) else $error("first gate");
    property p_gate_b;
        (second_port_in_o & ~second_port_ie_o & ~$past(second_port_ie_o)) == 0;
    endproperty
    a_gate_b: assert property (p_gate_b) else $error("second gate");
    property p_wake;
        $past(ce_i) && wake_o
            |-> !$stable(first_port_in_o) || !$stable(second_port_in_o);
    endproperty
    a_wake: assert property (p_wake) else $error("wake cause");
    property p_req;
        pin_req_o[0] && !(wr_i && addr_i == `DIEG_PIN_REQ_ADDR) |=> pin_req_o[0];
    endproperty
    a_req: assert property (p_req) else $error("request lost");
    property p_wo;
        rd_i && (addr_i == `DIEG_FIRST_GATE_ADDR
            || addr_i == `DIEG_SECOND_GATE_ADDR) |=> rdata_o == 8'h00;
    endproperty
    a_wo: assert property (p_wo) else $error("write-only read");
endmodule // dieg_checker
bind dieg_top dieg_checker dieg_checker_i (.clk_i, .reset_i, .ce_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .first_port_ie_o, .second_port_ie_o,
    .first_port_in_o, .second_port_in_o, .wake_o, .pin_req_o);

// file: verification/dieg_pin_model.sv
// pin world: levels chosen by the bench, crystal on first lines 7,6
// assumes the bench changes levels right after a clock edge
module dieg_pin_model (
    input wire clk_i,
    input wire osc_on_i,
    input wire [7:0] first_lvl_i,
    input wire [7:0] second_lvl_i,
    output wire [7:0] first_pin_o,
    output wire [7:0] second_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic osc_r = 1'b0;
    always @(posedge clk_i) osc_r <= ~osc_r;
    // crystal swings lines 7,6 in antiphase
    assign first_pin_o = osc_on_i ? {osc_r, ~osc_r, first_lvl_i[5:0]}
                                  : first_lvl_i;
    // analog lines appear as the level set
    assign second_pin_o = second_lvl_i;
endmodule // dieg_pin_model

// file: verification/tb_top.sv
// self-checking bench for the input gating block
// assumes the pin model on both ports; ce_i driven by the bench
`include "dieg_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic osc_on = 1'b0;
    logic ce = 1'b1;
    logic [7:0] lvl_a = 8'h00;
    logic [7:0] lvl_b = 8'h00;
    logic [7:0] rv;
    wire [7:0] rdata_o, pin_a, pin_b, ie_a, ie_b, in_a, in_b;
    wire wake_o, irq_o;
    wire [1:0] pin_req_o;
    int error_cnt = 0;
    int tests_run = 0;
    int wakes = 0;
    int cyc = 0;
    int w0;
    dieg_pin_model dieg_pin_model_i (.clk_i(clk_i), .osc_on_i(osc_on),
        .first_lvl_i(lvl_a), .second_lvl_i(lvl_b), .first_pin_o(pin_a),
        .second_pin_o(pin_b));
    dieg_top dieg_top_i (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .first_port_pin_i(pin_a),
        .second_port_pin_i(pin_b), .first_port_ie_o(ie_a),
        .second_port_ie_o(ie_b), .first_port_in_o(in_a),
        .second_port_in_o(in_b), .wake_o(wake_o), .pin_req_o(pin_req_o),
        .irq_o(irq_o));
    initial forever #10 clk_i = ~clk_i;
    task automatic report_and_stop();
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (wake_o === 1'b1)
            wakes <= wakes + 1;
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 rv = rdata_o;
        @(posedge clk_i);
    endtask
    initial begin
        int p, b;
        logic gated, sel;
        logic [1:0] hit;
        logic [7:0] g, a, m;
        tick(8);
        reset_i <= 1'b0;
        tick(1);
        chk(ie_a, 8'hFF);
        chk(ie_b, 8'hFF);
        rd(8'hFF);
        chk(rv, 8'h00);
        // each line: toggle with its gate cleared (first lines 2,1 stay enabled), re-enable, then a real edge
        for (int i = 0; i < 16; i++) begin
            p = i / 8;
            b = i % 8;
            m = 8'h01 << b;
            g = ~m;
            gated = !(p == 0 && (b == 1 || b == 2));
            sel = (p == 0 && b == 4) || (p == 1 && b == 5);
            hit[0] = sel ? (p == 1 && b == 5) : (p == 0 && b == 0);
            hit[1] = sel ? (p == 0 && b == 4) : (p == 1 && b == 0);
            a = p ? `DIEG_SECOND_GATE_ADDR : `DIEG_FIRST_GATE_ADDR;
            wr(`DIEG_EDGE_SEL_ADDR, sel ? 8'h30 : 8'h00);
            wr(`DIEG_PIN_REQ_ADDR, 8'h00);
            rd(`DIEG_EVT_STATUS_ADDR);
            wr(a, p ? g : g & `DIEG_FIRST_GATE_MASK);
            tick(4);
            chk(p ? ie_b : ie_a, p ? g : g | `DIEG_FIRST_UNGATED);
            w0 = wakes;
            if (p) lvl_b <= m;
            else lvl_a <= m;
            tick(6);
            chk(8'(wakes - w0), gated ? 8'h00 : 8'h01);
            chk(p ? in_b : in_a, gated ? 8'h00 : m);
            chk({6'h0, pin_req_o}, 8'h00);
            w0 = wakes;
            wr(a, p ? 8'hFF : `DIEG_FIRST_GATE_MASK);
            tick(5);
            chk(8'(wakes - w0), 8'h00);
            chk(p ? in_b : in_a, m);
            w0 = wakes;
            if (p) lvl_b <= 8'h00;
            else lvl_a <= 8'h00;
            tick(6);
            chk(8'(wakes - w0), 8'h01);
            chk({6'h0, pin_req_o}, {6'h0, hit});
            chk({7'h0, irq_o}, 8'h00);
            wr(`DIEG_EVT_MASK_ADDR, 8'h07);
            chk({7'h0, irq_o}, 8'h01);
            rd(`DIEG_EVT_STATUS_ADDR);
            chk(rv, {5'h0, hit, 1'b1});
            chk({7'h0, irq_o}, 8'h00);
            wr(`DIEG_EVT_MASK_ADDR, 8'h00);
            $display("line test %0d done", i);
        end
        // edge modes on first line0: rise only, fall only, none
        wr(`DIEG_EDGE_SEL_ADDR, 8'h01);
        lvl_a <= 8'h01;
        tick(6);
        chk({6'h0, pin_req_o}, 8'h01);
        rd(`DIEG_FIRST_LEVEL_ADDR);
        chk(rv, 8'h01);
        wr(`DIEG_PIN_REQ_ADDR, 8'h00);
        lvl_a <= 8'h00;
        tick(6);
        chk({6'h0, pin_req_o}, 8'h00);
        wr(`DIEG_EDGE_SEL_ADDR, 8'h02);
        lvl_a <= 8'h01;
        tick(6);
        chk({6'h0, pin_req_o}, 8'h00);
        lvl_a <= 8'h00;
        tick(6);
        chk({6'h0, pin_req_o}, 8'h01);
        wr(`DIEG_PIN_REQ_ADDR, 8'h00);
        wr(`DIEG_EDGE_SEL_ADDR, 8'h03);
        lvl_a <= 8'h01;
        tick(6);
        lvl_a <= 8'h00;
        tick(6);
        chk({6'h0, pin_req_o}, 8'h00);
        wr(`DIEG_EDGE_SEL_ADDR, 8'h00);
        $display("edge mode test done");
        // clock enable low ignores writes and pin changes
        w0 = wakes;
        ce <= 1'b0;
        wr(`DIEG_SECOND_GATE_ADDR, 8'h00);
        lvl_b <= 8'hFF;
        tick(4);
        ce <= 1'b1;
        lvl_b <= 8'h00;
        chk(ie_b, 8'hFF);
        chk(in_b, 8'h00);
        tick(4);
        chk(8'(wakes - w0), 8'h00);
        $display("clock enable test done");
        wr(`DIEG_FIRST_GATE_ADDR, 8'h39);
        rd(`DIEG_FIRST_GATE_ADDR);
        chk(rv, 8'h00);
        w0 = wakes;
        osc_on <= 1'b1;
        tick(20);
        chk(8'(wakes - w0), 8'h00);
        osc_on <= 1'b0;
        $display("crystal test done");
        reset_i <= 1'b1;
        tick(2);
        reset_i <= 1'b0;
        tick(1);
        chk(ie_a, 8'hFF);
        chk(in_a, 8'h00);
        $display("reset test done");
        report_and_stop();
    end
endmodule // tb_top
